// ### core/smsd_defs.svh
/*
  Timing counts and reset values for the stacked memory select decode.
  Assumes inclusion by bare name from the NAND core and top design files.
*/
`ifndef SMSD_DEFS_SVH
`define SMSD_DEFS_SVH

`define SMSD_BUSY_NS        100
`define SMSD_CLK_NS         10
`define SMSD_BUSY_CYCLES    ((`SMSD_BUSY_NS + `SMSD_CLK_NS - 1) / `SMSD_CLK_NS)
`define SMSD_NAND_CMD_READ  8'h00
`define SMSD_NAND_CMD_PROG  8'h10
`define SMSD_NAND_CMD_ERASE 8'hd0
`define SMSD_RST_CMD        8'h00
`define SMSD_RST_ADDR       8'h00

`endif

// ### core/smsd_pkg.sv
/*
  Types shared by the stacked memory select decode.
  Assumes the defs header is on the include path.
*/
package smsd_pkg;
  typedef enum logic [1:0] {
    SMSD_BALL_NAND,
    SMSD_BALL_ALT
  } smsd_ball_e;

  typedef enum {
    SMSD_NAND_IDLE,
    SMSD_NAND_BUSY
  } smsd_nand_e;
endpackage

// ### core/smsd_sel_if.sv
/*
  Decoded select group passed from the decoder to the NAND core.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface smsd_sel_if;
  logic       nand_we_n;
  logic       nand_re_n;
  logic       cle;
  logic       ale;
  logic [7:0] bus;
  modport src (output nand_we_n, nand_re_n, cle, ale, bus);
  modport dst (input nand_we_n, nand_re_n, cle, ale, bus);
endinterface
`default_nettype wire

// ### core/smsd_nand_core.sv
/*
  NAND latch, read-drive and ready/busy logic.
  Assumes synchronised strobes arriving on the interface.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smsd_defs.svh"
module smsd_nand_core
  import smsd_pkg::*;
#(
  parameter int BUSY_CYCLES = `SMSD_BUSY_CYCLES
) (
  input  wire logic   clk_sys_i,
  input  wire logic   rst_i,
  smsd_sel_if.dst     sel,
  output logic [7:0]  cmd_o,
  output logic [7:0]  addr_o,
  output logic        ready_o,
  output logic        drive_o
);
  // Counter needs a count of at least 1 and the busy-end check at most 300; the guard takes 1 to 299
  if (BUSY_CYCLES < 1 || BUSY_CYCLES > 299) begin : g_busy_check
    $error("BUSY_CYCLES must lie between 1 and 299");
  end

  logic       we_q;
  logic [15:0] cnt_q;
  smsd_nand_e st_q;
  wire        we_rise = sel.nand_we_n && !we_q;
  wire        cmd_go  = we_rise && sel.cle && !sel.ale;
  wire        adr_go  = we_rise && sel.ale && !sel.cle;
  wire        start   = cmd_go && (sel.bus == `SMSD_NAND_CMD_READ ||
                        sel.bus == `SMSD_NAND_CMD_PROG || sel.bus == `SMSD_NAND_CMD_ERASE);

  assign ready_o = (st_q == SMSD_NAND_IDLE);
  assign drive_o = !sel.nand_re_n;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      we_q   <= 1'b1;
      cmd_o  <= `SMSD_RST_CMD;
      addr_o <= `SMSD_RST_ADDR;
      st_q   <= SMSD_NAND_IDLE;
      cnt_q  <= '0;
    end else begin
      we_q <= sel.nand_we_n;
      if (cmd_go) cmd_o <= sel.bus;
      if (adr_go) addr_o <= sel.bus;
      unique case (st_q)
        SMSD_NAND_IDLE: begin
          if (start) begin
            st_q  <= SMSD_NAND_BUSY;
            cnt_q <= 16'(BUSY_CYCLES);
          end
        end
        SMSD_NAND_BUSY: begin
          if (cnt_q == 16'h0001) st_q <= SMSD_NAND_IDLE;
          cnt_q <= cnt_q - 16'h0001;
        end
      endcase
    end
  end

  chk_busy_after_cmd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start && st_q == SMSD_NAND_IDLE) |=> !ready_o)
    else $error("busy not raised after command");
  chk_busy_ends: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(st_q == SMSD_NAND_BUSY) |-> ##[1:300] ready_o)
    else $error("busy did not end");
  chk_addr_capture: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    adr_go |=> addr_o == $past(sel.bus))
    else $error("address not captured");
  chk_cmd_capture: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cmd_go |=> cmd_o == $past(sel.bus))
    else $error("command not captured");
endmodule
`default_nettype wire

// ### core/smsd_top.sv
/*
  Stacked memory select decode: NAND, PSRAM and SRAM control decode.
  Assumes all pins come asynchronously from the host and are synchronised here.
*/
// Summary of operation
// - ALE high latches bus as address on write strobe rising edge.
// - NAND drives data while read strobe low, else high impedance.
// - Ready/busy low during read, program or erase, high when ready.
// - NAND writes latch only on the write strobe rising edge, never while the host holds it low.
// - PSRAM register access high selects refresh or bus control register.
// - Async PSRAM config input low selects config register and low power.
// - Low PSRAM select picks its die; high gives standby and hi-z.
// - SRAM selected only with low select low and high select high.
// - Low byte enables open upper and lower data lanes; high masks.
// - Shared balls carry one function chosen by die combination.
// - CLE high latches bus as command on write strobe rising edge.
// - Wait driven only when selected with output enable low.
`timescale 1ns/1ns
`default_nettype none
`include "smsd_defs.svh"
module smsd_top
  import smsd_pkg::*;
#(
  parameter smsd_ball_e BALL_FUNC = SMSD_BALL_NAND,
  parameter bit         SYNC_PSRAM = 1'b1
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       shared_h9_i,
  input  wire logic       shared_j2_i,
  input  wire logic       shared_k9_i,
  input  wire logic       nand_cle_i,
  input  wire logic       nand_ale_i,
  input  wire logic [7:0] ad_i,
  input  wire logic [1:0] psram_sel_n_i,
  input  wire logic       sram_select_high_i,
  input  wire logic       ram_oe_n_i,
  input  wire logic       ram_upper_byte_en_n_i,
  input  wire logic       ram_lower_byte_en_n_i,
  input  wire logic       psram_wait_i,
  output logic            nand_ready_busy_n_o,
  output logic            nand_data_oe_n_o,
  output logic [7:0]      nand_cmd_o,
  output logic [7:0]      nand_addr_o,
  output logic [1:0]      psram_die_active_o,
  output logic            psram_reg_access_o,
  output logic            sram_active_o,
  output logic [1:0]      lane_en_o,
  output logic            wait_o,
  output logic            wait_oe_n_o
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int W = 20;
  logic [W-1:0] s1_q, s2_q;
  wire  [W-1:0] raw = {shared_h9_i, shared_j2_i, shared_k9_i, nand_cle_i, nand_ale_i,
                       ad_i, psram_sel_n_i, sram_select_high_i, ram_oe_n_i,
                       ram_upper_byte_en_n_i, ram_lower_byte_en_n_i, psram_wait_i};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_q <= {W{1'b1}};
      s2_q <= {W{1'b1}};
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  wire       h9_s  = s2_q[19];
  wire       j2_s  = s2_q[18];
  wire       k9_s  = s2_q[17];
  wire       cle_s = s2_q[16];
  wire       ale_s = s2_q[15];
  wire [7:0] ad_s  = s2_q[14:7];
  wire [1:0] ps_s  = s2_q[6:5];
  wire       cs2_s = s2_q[4];
  wire       oe_s  = s2_q[3];
  wire       ub_s  = s2_q[2];
  wire       lb_s  = s2_q[1];
  wire       wt_s  = s2_q[0];

  // ---------------------------------------------------------------
  // Shared ball decode
  // ---------------------------------------------------------------
  wire nand_fit  = (BALL_FUNC == SMSD_BALL_NAND);
  wire nand_re_n = nand_fit ? h9_s : 1'b1;
  wire nand_we_n = nand_fit ? j2_s : 1'b1;
  wire sram_low  = nand_fit ? 1'b1 : j2_s;
  wire sram_sel  = !sram_low && cs2_s;
  wire reg_acc   = SYNC_PSRAM ? k9_s : !k9_s;
  wire [1:0] ps_act = ~ps_s;
  wire any_ram   = |ps_act || sram_sel;
  wire [1:0] lane = any_ram ? {!ub_s, !lb_s} : 2'h0;
  wire wait_drv  = |ps_act && !oe_s;

  smsd_sel_if sel ();
  assign sel.nand_we_n = nand_we_n;
  assign sel.nand_re_n = nand_re_n;
  assign sel.cle       = cle_s;
  assign sel.ale       = ale_s;
  assign sel.bus       = ad_s;

  logic [7:0] cmd_w, addr_w;
  logic       ready_w, drive_w;

  smsd_nand_core u_nand (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .sel       (sel),
    .cmd_o     (cmd_w),
    .addr_o    (addr_w),
    .ready_o   (ready_w),
    .drive_o   (drive_w)
  );

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nand_ready_busy_n_o <= 1'b1;
      nand_data_oe_n_o    <= 1'b1;
      nand_cmd_o          <= `SMSD_RST_CMD;
      nand_addr_o         <= `SMSD_RST_ADDR;
      psram_die_active_o  <= 2'h0;
      psram_reg_access_o  <= 1'b0;
      sram_active_o       <= 1'b0;
      lane_en_o           <= 2'h0;
      wait_o              <= 1'b0;
      wait_oe_n_o         <= 1'b1;
    end else begin
      nand_ready_busy_n_o <= ready_w;
      nand_data_oe_n_o    <= !(drive_w && nand_fit);
      nand_cmd_o          <= cmd_w;
      nand_addr_o         <= addr_w;
      psram_die_active_o  <= ps_act;
      psram_reg_access_o  <= reg_acc && |ps_act;
      sram_active_o       <= sram_sel;
      lane_en_o           <= lane;
      wait_o              <= wait_drv ? wt_s : 1'b0;
      wait_oe_n_o         <= !wait_drv;
    end
  end

  chk_sram_select: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    sram_active_o |-> $past(cs2_s) && $past(!sram_low))
    else $error("sram active without both selects");
  chk_wait_hiz: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ($past(ps_s) == 2'h3) |-> wait_oe_n_o)
    else $error("wait driven while deselected");
  chk_wait_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !wait_oe_n_o |-> $past(!oe_s))
    else $error("wait driven with output enable high");
  chk_lane_mask: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    lane_en_o[1] |-> $past(!ub_s))
    else $error("upper lane enabled while masked");
  chk_nand_drive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !nand_data_oe_n_o |-> $past(!nand_re_n))
    else $error("nand driving with read strobe high");
  chk_reg_access: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    psram_reg_access_o |-> $past(reg_acc))
    else $error("register access without enable");
endmodule
`default_nettype wire

// ### verification/smsd_host_bfm.sv
/*
  Host controller model: NAND write cycles on the shared bus.
  Assumes the system clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module smsd_host_bfm
  import smsd_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       cle_i,
  input  wire logic [7:0] byte_i,
  output logic            we_n_o,
  output logic            cle_o,
  output logic            ale_o,
  output logic [7:0]      ad_o,
  output logic            busy_o
);
  logic [2:0] cnt_q;
  logic       cle_q;
  logic [7:0] byte_q;
  wire        take = start_i && (cnt_q == 3'h0);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q  <= 3'h0;
      cle_q  <= 1'b0;
      byte_q <= 8'h00;
    end else if (take) begin
      cnt_q  <= 3'h6;
      cle_q  <= cle_i;
      byte_q <= byte_i;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  // Strobe low three cycles, then high three
  assign we_n_o = (cnt_q < 3'h4);
  // One latch enable per strobe, held past the rising edge
  assign cle_o  = (cnt_q >= 3'h2) && cle_q;
  assign ale_o  = (cnt_q >= 3'h2) && !cle_q;
  // Released bus shows the inverse of the last byte
  assign ad_o   = (cnt_q != 3'h0) ? byte_q : ~byte_q;
  assign busy_o = (cnt_q != 3'h0);
endmodule
`default_nettype wire

// ### verification/testbench.sv
/*
  Self-checking bench for the stacked memory select decode.
  Covers the NAND ball function with the synchronous PSRAM build and the alternate ball function with the async build.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       h9 = 1'b1, k9 = 1'b0, hi = 1'b0, oe = 1'b1, ub = 1'b1, lb = 1'b1, wt = 1'b0;
  logic       go = 1'b0, cl = 1'b0, lo = 1'b1, sr;
  logic       a_rdy, a_doe, a_pra, a_sra, a_wo, a_woe;
  logic [7:0] a_cmd, a_addr;
  logic [1:0] a_pda, a_lane;
  logic [1:0] psn = 2'b11, pe;
  logic [7:0] by = 8'h00, cmds [3] = '{8'h00, 8'h10, 8'hd0};
  wire        we_n, cle, ale, bbusy;
  wire  [7:0] ad;
  logic       rdy, doe, pra, sra, wo, woe, sel;
  logic [7:0] cmd, addr;
  logic [1:0] pda, lane;
  int         errors = 0, n_compared = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  smsd_host_bfm host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(go), .cle_i(cl),
    .byte_i(by), .we_n_o(we_n), .cle_o(cle), .ale_o(ale), .ad_o(ad), .busy_o(bbusy));
  smsd_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .shared_h9_i(h9), .shared_j2_i(we_n),
    .shared_k9_i(k9), .nand_cle_i(cle), .nand_ale_i(ale), .ad_i(ad), .psram_sel_n_i(psn),
    .sram_select_high_i(hi), .ram_oe_n_i(oe), .ram_upper_byte_en_n_i(ub),
    .ram_lower_byte_en_n_i(lb), .psram_wait_i(wt), .nand_ready_busy_n_o(rdy),
    .nand_data_oe_n_o(doe), .nand_cmd_o(cmd), .nand_addr_o(addr), .psram_die_active_o(pda),
    .psram_reg_access_o(pra), .sram_active_o(sra), .lane_en_o(lane), .wait_o(wo),
    .wait_oe_n_o(woe));
  // Second build: shared balls carry the SRAM select and the async PSRAM mode pin
  smsd_top #(.BALL_FUNC(smsd_pkg::SMSD_BALL_ALT), .SYNC_PSRAM(1'b0)) dut_alt (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .shared_h9_i(h9), .shared_j2_i(lo),
    .shared_k9_i(k9), .nand_cle_i(cle), .nand_ale_i(ale), .ad_i(ad), .psram_sel_n_i(psn),
    .sram_select_high_i(hi), .ram_oe_n_i(oe), .ram_upper_byte_en_n_i(ub),
    .ram_lower_byte_en_n_i(lb), .psram_wait_i(wt), .nand_ready_busy_n_o(a_rdy),
    .nand_data_oe_n_o(a_doe), .nand_cmd_o(a_cmd), .nand_addr_o(a_addr),
    .psram_die_active_o(a_pda), .psram_reg_access_o(a_pra), .sram_active_o(a_sra),
    .lane_en_o(a_lane), .wait_o(a_wo), .wait_oe_n_o(a_woe));
  function automatic logic [1:0] exp_lanes(logic s, logic u, logic l);
    return s ? {~u, ~l} : 2'b00;
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (e !== g) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // NAND write cycle, then latch and busy checks
  task automatic nand_wr(logic c, logic [7:0] b);
    int i;
    @(posedge clk_sys_i);
    go <= 1'b1;
    cl <= c;
    by <= b;
    @(posedge clk_sys_i);
    go <= 1'b0;
    for (i = 0; i < 20 && (i < 2 || bbusy); i++) tick(1);
    chk("host_idle", 8'h00, {7'h0, bbusy});
    tick(3);
    if (c) chk("cmd", b, cmd);
    else chk("addr", b, addr);
    if (c && (b == 8'h00 || b == 8'h10 || b == 8'hd0)) begin
      chk("ready_busy_n", 8'h00, {7'h0, rdy});
      for (i = 0; i < 30 && rdy !== 1'b1; i++) tick(1);
    end
    chk("ready_busy_n", 8'h01, {7'h0, rdy});
  endtask
  initial begin
    #900000;
    errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h74c93086));
    tick(12);
    chk("reset", 8'h03, {6'h0, rdy, doe});
    rst_i <= 1'b0;
    tick(2);
    foreach (cmds[k]) nand_wr(1'b1, cmds[k]);
    nand_wr(1'b0, 8'(($urandom)));
    nand_wr(1'b1, 8'h55);
    nand_wr(1'b0, 8'hff);
    for (int n = 0; n < 24; n++) begin
      @(posedge clk_sys_i);
      h9  <= (n > 0) ? 1'($urandom) : 1'b1;
      k9  <= 1'($urandom);
      lo  <= (n > 0) ? 1'($urandom) : 1'b1;
      psn <= (n > 0) ? 2'($urandom) : 2'b11;
      hi  <= 1'($urandom);
      oe  <= 1'($urandom);
      ub  <= 1'($urandom);
      lb  <= 1'($urandom);
      wt  <= 1'($urandom);
      tick(4);
      pe = ~psn;
      sel = (pe != 2'b00);
      sr  = !lo && hi;
      chk("alt_data_oe_n", 8'h01, {7'h0, a_doe});
      chk("alt_die_active", {6'h0, pe}, {6'h0, a_pda});
      chk("alt_sram_active", {7'h0, sr}, {7'h0, a_sra});
      chk("alt_lanes", {6'h0, exp_lanes(sel || sr, ub, lb)}, {6'h0, a_lane});
      chk("alt_reg_access", {7'h0, sel && !k9}, {7'h0, a_pra});
      chk("alt_wait_oe_n", {7'h0, !(sel && !oe)}, {7'h0, a_woe});
      chk("alt_wait", {7'h0, sel && !oe && wt}, {7'h0, a_wo});
      chk("data_oe_n", {7'h0, h9}, {7'h0, doe});
      chk("die_active", {6'h0, pe}, {6'h0, pda});
      chk("sram_active", 8'h00, {7'h0, sra});
      chk("lanes", {6'h0, exp_lanes(sel, ub, lb)}, {6'h0, lane});
      chk("wait_oe_n", {7'h0, !(sel && !oe)}, {7'h0, woe});
      chk("wait", {7'h0, sel && !oe && wt}, {7'h0, wo});
      chk("reg_access", {7'h0, sel && k9}, {7'h0, pra});
    end
    chk("alt_ready_busy_n", 8'h01, {7'h0, a_rdy});
    chk("alt_cmd", 8'h00, a_cmd);
    chk("alt_addr", 8'h00, a_addr);
    conclude();
  end
endmodule
`default_nettype wire
